// ---- srca_pkg.sv ----
// Shared constants for the session receive width adapter.
// Assumes one 20 MHz clock drives both the gathering and the delivery side.
package srca_pkg;

    // Input side shape
    localparam int RX_COUNT = 4;
    localparam int IN_W = 32;
    localparam int LOCAL_SS_W = 2;
    localparam int RX_IDX_W = 2;

    // Output side shape
    localparam int OUT_W = 64;
    localparam int SSID_W = 4;
    localparam int TAG_W = 16;
    localparam int BE_W = 8;

    // Buffer entry layout
    localparam int ENTRY_W = 78;
    localparam int DATA_LSB = 0;
    localparam int BE_LSB = 64;
    localparam int LAST_BIT = 72;
    localparam int ERR_BIT = 73;
    localparam int SSID_LSB = 74;

    // Buffer depth and fill level
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FILL_LIMIT = 5'h0E;

    // Fixed field values
    localparam logic [IN_W-1:0] DUMMY_WORD = 32'h0000_0000;
    localparam logic [BE_W-1:0] BE_FULL = 8'hFF;
    localparam logic [BE_W-1:0] BE_LOW_HALF = 8'h0F;

    // Clock rate
    localparam int CLK_HZ = 20_000_000;

endpackage : srca_pkg

// ---- srca_fifo.sv ----
// First-word-fall-through buffer holding whole 78-bit entries.
// Assumes the writer never writes when full; a read when empty is ignored.
`timescale 1ns/1ns
`default_nettype none
module srca_fifo
    import srca_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_en_i,
    input wire logic [ENTRY_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [ENTRY_W-1:0] rd_data_o,
    output logic empty_o,
    output logic [CNT_W-1:0] count_o
);

    logic [ENTRY_W-1:0] mem [0:FIFO_DEPTH-1]; // Entry storage
    logic [PTR_W-1:0] wr_ptr; // Next slot to fill
    logic [PTR_W-1:0] rd_ptr; // Slot shown at the head
    logic [CNT_W-1:0] fill; // Entries held
    wire do_wr = wr_en_i;
    wire do_rd = rd_en_i && (fill != '0);

    // Head entry is visible before the read, so data and read enable coincide
    assign rd_data_o = mem[rd_ptr];
    assign empty_o = (fill == '0);
    assign count_o = fill;

    // Storage write, no reset needed on data
    always_ff @(posedge clk_i)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= wr_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + CNT_W'(do_wr) - CNT_W'(do_rd);
        end
    end

endmodule : srca_fifo
`default_nettype wire

// ---- srca_adapter.sv ----
// Session receive adapter: pairs 32-bit words into 64-bit entries and delivers them
// with a per-packet session tag. Assumes upstream receivers honour in_word_ready_o.
// What this block does
// - 64-bit data stream plus 16-bit tag stream
// - Tag is 4-bit binary session number
// - One tag per packet, with first word
// - Buffer moves 32-bit words to 64-bit words
// - Entry layout: data, enables, last, error, session
// - Latch session at packet start, hold it
// - Shift words, toggle half, write on pairs
// - No buffer write while input idle
// - Aligned final word writes without padding
// - Unaligned final word requests one dummy word
// - Padding step writes last word plus dummy
// - Buffer head valid with read strobe
// - First word read whenever buffer nonempty
// - Later words read only when accepted
// - First read loads tag, raises tag valid
// - Every read loads word, raises valid
// - Tag valid holds until tag accept
// - Accepted word without read drops valid
// - Last entry marks end, rearms first-word
// - Four receivers in, sixteen sessions out
`timescale 1ns/1ns
`default_nettype none
module srca_adapter
    import srca_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [RX_COUNT-1:0] in_word_valid_i,
    input wire logic [RX_COUNT-1:0] in_start_of_packet_i,
    input wire logic [RX_COUNT-1:0] in_end_of_packet_i,
    input wire logic [RX_COUNT-1:0] in_error_i,
    input wire logic [RX_COUNT*IN_W-1:0] in_word_i,
    input wire logic [RX_COUNT*LOCAL_SS_W-1:0] in_local_session_i,
    output logic in_word_ready_o,
    output logic [OUT_W-1:0] out_word_o,
    output logic out_word_valid_o,
    output logic out_packet_end_o,
    input wire logic out_word_accept_i,
    output logic [TAG_W-1:0] out_session_tag_o,
    output logic out_tag_valid_o,
    input wire logic out_tag_accept_i
);

    // Per-receiver selection chains, one link per receiver
    logic [IN_W-1:0] chain_word [0:RX_COUNT];
    logic [SSID_W-1:0] chain_ssid [0:RX_COUNT];
    logic [RX_COUNT:0] chain_valid;
    logic [RX_COUNT:0] chain_sop;
    logic [RX_COUNT:0] chain_eop;
    logic [RX_COUNT:0] chain_err;

    assign chain_word[0] = '0;
    assign chain_ssid[0] = '0;
    assign chain_valid[0] = 1'b0;
    assign chain_sop[0] = 1'b0;
    assign chain_eop[0] = 1'b0;
    assign chain_err[0] = 1'b0;

    // Gather the one active receiver; OR merge is safe as at most one is valid
    genvar g;
    generate
        for (g = 0; g < RX_COUNT; g++)
        begin : g_rx
            wire hit = in_word_valid_i[g];
            wire [SSID_W-1:0] ssid_g =
                {RX_IDX_W'(g), in_local_session_i[g*LOCAL_SS_W +: LOCAL_SS_W]};
            assign chain_word[g+1] = chain_word[g] | (hit ? in_word_i[g*IN_W +: IN_W] : '0);
            assign chain_ssid[g+1] = chain_ssid[g] | (hit ? ssid_g : '0);
            assign chain_valid[g+1] = chain_valid[g] | hit;
            assign chain_sop[g+1] = chain_sop[g] | (hit & in_start_of_packet_i[g]);
            assign chain_eop[g+1] = chain_eop[g] | (hit & in_end_of_packet_i[g]);
            assign chain_err[g+1] = chain_err[g] | (hit & in_error_i[g]);
        end
    endgenerate

    // Write side state
    logic [SSID_W-1:0] latched_session_id; // Session of the packet in flight
    logic [IN_W-1:0] upper_word_reg; // Newest word
    logic [IN_W-1:0] lower_word_reg; // Older word of the pair
    logic half_select_toggle; // High when a lone word waits for its partner
    logic fifo_write_strobe; // Entry in the word registers is written now
    logic pad_word_flag; // Dummy step pending
    logic entry_last; // Entry closes a packet
    logic entry_err; // Entry carries the packet error
    logic [BE_W-1:0] entry_be; // Byte enables of the entry
    logic pkt_err; // Error collected over the packet so far

    // Read side state
    logic awaiting_first_word; // Next head entry opens a packet
    logic [ENTRY_W-1:0] fifo_read_word; // Head entry
    logic fifo_empty_flag; // Buffer holds nothing
    logic [CNT_W-1:0] fifo_fill; // Entries held

    // Input decode
    wire word_take = chain_valid[RX_COUNT] && in_word_ready_o;
    wire word_sop = word_take && chain_sop[RX_COUNT];
    wire word_eop = word_take && chain_eop[RX_COUNT];
    wire word_err = chain_err[RX_COUNT];
    wire [IN_W-1:0] sel_word = chain_word[RX_COUNT];
    wire pair_done = word_take && half_select_toggle;
    wire pad_needed = word_eop && !half_select_toggle;
    wire [SSID_W-1:0] next_latched_session_id =
        word_sop ? chain_ssid[RX_COUNT] : latched_session_id;
    wire next_pkt_err = word_sop ? word_err : (pkt_err | (word_take & word_err));

    // Read decode
    wire fifo_read_strobe = !fifo_empty_flag
        && (awaiting_first_word || out_word_accept_i);
    wire head_last = fifo_read_word[LAST_BIT];
    wire [OUT_W-1:0] head_data = fifo_read_word[DATA_LSB +: OUT_W];
    wire [SSID_W-1:0] head_ssid = fifo_read_word[SSID_LSB +: SSID_W];

    // Entry packing, first-received word in the low half
    wire [ENTRY_W-1:0] entry_word =
        {latched_session_id, entry_err, entry_last, entry_be,
         upper_word_reg, lower_word_reg};

    // Fill level after this cycle decides whether one more word fits plus a pad
    wire [CNT_W-1:0] next_fill = fifo_fill + CNT_W'(fifo_write_strobe)
        - CNT_W'(fifo_read_strobe);
    wire next_ready = (next_fill <= FILL_LIMIT) && !pad_needed;

    // Session latch and packet error
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            latched_session_id <= '0;
            pkt_err <= 1'b0;
        end
        else
        begin
            latched_session_id <= next_latched_session_id;
            pkt_err <= next_pkt_err;
        end
    end

    // Word pairing and padding
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            upper_word_reg <= '0;
            lower_word_reg <= '0;
            half_select_toggle <= 1'b0;
            pad_word_flag <= 1'b0;
            fifo_write_strobe <= 1'b0;
        end
        else if (pad_word_flag)
        begin
            // Dummy step: last real word drops low, dummy fills high half
            lower_word_reg <= upper_word_reg;
            upper_word_reg <= DUMMY_WORD;
            half_select_toggle <= 1'b0;
            pad_word_flag <= 1'b0;
            fifo_write_strobe <= 1'b1;
        end
        else
        begin
            if (word_take)
            begin
                upper_word_reg <= sel_word;
                lower_word_reg <= upper_word_reg;
                half_select_toggle <= !half_select_toggle;
            end
            pad_word_flag <= pad_needed;
            fifo_write_strobe <= pair_done;
        end
    end

    // Entry side fields
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            entry_last <= 1'b0;
            entry_err <= 1'b0;
            entry_be <= '0;
        end
        else if (pad_word_flag)
        begin
            entry_last <= 1'b1;
            entry_be <= BE_LOW_HALF;
        end
        else
        begin
            entry_last <= word_eop;
            entry_err <= next_pkt_err;
            entry_be <= BE_FULL;
        end
    end

    // Back-pressure towards the receivers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            in_word_ready_o <= 1'b0;
        end
        else
        begin
            in_word_ready_o <= next_ready;
        end
    end

    // Entry buffer between gathering and delivery
    srca_fifo u_fifo
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_en_i(fifo_write_strobe),
        .wr_data_i(entry_word),
        .rd_en_i(fifo_read_strobe),
        .rd_data_o(fifo_read_word),
        .empty_o(fifo_empty_flag),
        .count_o(fifo_fill)
    );

    // First-word tracker
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            awaiting_first_word <= 1'b1;
        end
        else if (fifo_read_strobe)
        begin
            awaiting_first_word <= head_last;
        end
    end

    // Data stream output
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            out_word_o <= '0;
            out_word_valid_o <= 1'b0;
            out_packet_end_o <= 1'b0;
        end
        else if (fifo_read_strobe)
        begin
            out_word_o <= head_data;
            out_word_valid_o <= 1'b1;
            out_packet_end_o <= head_last;
        end
        else if (out_word_accept_i)
        begin
            out_word_valid_o <= 1'b0;
        end
    end

    // Tag stream output, a new tag wins over an acknowledge
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            out_session_tag_o <= '0;
            out_tag_valid_o <= 1'b0;
        end
        else if (fifo_read_strobe && awaiting_first_word)
        begin
            out_session_tag_o <= TAG_W'(head_ssid);
            out_tag_valid_o <= 1'b1;
        end
        else if (out_tag_accept_i)
        begin
            out_tag_valid_o <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_session_hold: assert property (!word_sop |=> $stable(latched_session_id))
        else $error("session id changed without packet start");
    a_pair_write: assert property (pair_done && !pad_word_flag |=> fifo_write_strobe)
        else $error("pair not written");
    a_idle_no_write: assert property (!word_take && !pad_word_flag |=> !fifo_write_strobe)
        else $error("write without input word");
    a_aligned_end: assert property (word_eop && half_select_toggle && !pad_word_flag
        |=> fifo_write_strobe && !pad_word_flag && entry_last)
        else $error("aligned end padded or missed");
    a_pad_step: assert property (pad_needed && !pad_word_flag
        |=> pad_word_flag ##1 (fifo_write_strobe && upper_word_reg == DUMMY_WORD
        && entry_be == BE_LOW_HALF && entry_last))
        else $error("padding step wrong");
    a_first_read: assert property (awaiting_first_word && !fifo_empty_flag
        |=> out_word_valid_o && out_tag_valid_o)
        else $error("first word not read");
    a_later_read: assert property (!awaiting_first_word && !out_word_accept_i
        |=> $stable(out_word_o) && $stable(out_word_valid_o))
        else $error("read without accept");
    a_tag_load: assert property (fifo_read_strobe && awaiting_first_word
        |=> out_tag_valid_o && out_session_tag_o == TAG_W'($past(head_ssid)))
        else $error("tag not loaded");
    a_word_load: assert property (fifo_read_strobe
        |=> out_word_valid_o && out_word_o == $past(head_data))
        else $error("word not loaded");
    a_tag_hold: assert property (out_tag_valid_o && !out_tag_accept_i |=> out_tag_valid_o)
        else $error("tag dropped early");
    a_valid_drop: assert property (out_word_valid_o && out_word_accept_i
        && !fifo_read_strobe |=> !out_word_valid_o)
        else $error("valid kept after accept");
    a_last_rearm: assert property (fifo_read_strobe && head_last
        |=> out_packet_end_o && awaiting_first_word)
        else $error("end not marked");

    c_padded_packet: cover property (pad_needed ##2 fifo_write_strobe);
    c_aligned_packet: cover property (word_eop && half_select_toggle);
    c_tag_with_word: cover property (out_tag_valid_o && out_word_valid_o && out_tag_accept_i);
    c_stall: cover property (out_word_valid_o && !out_word_accept_i && !fifo_empty_flag);

endmodule : srca_adapter
`default_nettype wire

// ---- srca_rx_model.sv ----
// Upstream receiver model: offers words from one of four receivers at a time.
// Assumes the bench calls its tasks and clk_i is the adapter clock.
`timescale 1ns/1ns
`default_nettype none
module srca_rx_model
    import srca_pkg::*;
(
    input wire logic clk_i,
    input wire logic ready_i,
    output logic [RX_COUNT-1:0] valid_o,
    output logic [RX_COUNT-1:0] sop_o,
    output logic [RX_COUNT-1:0] eop_o,
    output logic [RX_COUNT-1:0] err_o,
    output logic [RX_COUNT*IN_W-1:0] word_o,
    output logic [RX_COUNT*LOCAL_SS_W-1:0] ls_o
);
    // Start with every receiver quiet
    initial
    begin
        word_o = '0;
        ls_o = '0;
        idle();
    end

    // Released words show inverted data, never a stale word
    task automatic idle();
        valid_o = '0;
        sop_o = '0;
        eop_o = '0;
        err_o = '0;
        word_o = ~word_o;
    endtask : idle

    // Offer one word and hold it until the edge that takes it
    task automatic send_word(input int rx, input logic [1:0] ls, input logic sop,
        input logic eop, input logic err, input logic [IN_W-1:0] w);
        logic [RX_COUNT*IN_W-1:0] t;
        logic [RX_COUNT*LOCAL_SS_W-1:0] s;
        @(negedge clk_i);
        t = ~word_o;
        t[rx*IN_W +: IN_W] = w;
        s = ls_o;
        s[rx*LOCAL_SS_W +: LOCAL_SS_W] = ls;
        word_o = t;
        ls_o = s;
        valid_o = RX_COUNT'(1) << rx;
        sop_o = RX_COUNT'(sop) << rx;
        eop_o = RX_COUNT'(eop) << rx;
        err_o = RX_COUNT'(err) << rx;
        while (ready_i !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
    endtask : send_word
endmodule : srca_rx_model
`default_nettype wire

// ---- srca_adapter_tb_top.sv ----
// Bench for the session receive adapter: corner packets, random traffic, a fill.
// Assumes srca_rx_model drives the receivers; the downstream side lives here.
`timescale 1ns/1ns
`default_nettype none
module srca_adapter_tb_top
    import srca_pkg::*;
;
    logic clk_i;
    logic nrst_i;
    logic out_word_accept_i = 1'b0;
    logic out_tag_accept_i = 1'b0;
    logic [RX_COUNT-1:0] in_word_valid, in_start_of_packet, in_end_of_packet, in_error;
    logic [RX_COUNT*IN_W-1:0] in_word;
    logic [RX_COUNT*LOCAL_SS_W-1:0] in_local_session;
    logic in_word_ready, out_word_valid, out_packet_end, out_tag_valid;
    logic acc, tacc, stall, gaps;
    logic [OUT_W-1:0] out_word;
    logic [TAG_W-1:0] out_session_tag;
    logic [OUT_W:0] exp_e;
    logic [OUT_W:0] exp_q[$]; // Expected entries, top bit marks packet end
    logic [TAG_W-1:0] tag_q[$]; // Expected tags in packet order
    integer seed = 32'h5956;
    integer seed_a = 32'h5956;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    // 20 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    srca_adapter DUT (.clk_i(clk_i), .nrst_i(nrst_i), .in_word_valid_i(in_word_valid),
        .in_start_of_packet_i(in_start_of_packet), .in_end_of_packet_i(in_end_of_packet),
        .in_error_i(in_error), .in_word_i(in_word), .in_local_session_i(in_local_session),
        .in_word_ready_o(in_word_ready), .out_word_o(out_word),
        .out_word_valid_o(out_word_valid), .out_packet_end_o(out_packet_end),
        .out_word_accept_i(out_word_accept_i), .out_session_tag_o(out_session_tag),
        .out_tag_valid_o(out_tag_valid), .out_tag_accept_i(out_tag_accept_i));

    srca_rx_model RX (.clk_i(clk_i), .ready_i(in_word_ready), .valid_o(in_word_valid),
        .sop_o(in_start_of_packet), .eop_o(in_end_of_packet), .err_o(in_error),
        .word_o(in_word), .ls_o(in_local_session));

    // Session number is four times receiver plus local session
    function automatic logic [TAG_W-1:0] calc_tag(input int rx, input int ls);
        return TAG_W'(rx * 4 + ls);
    endfunction : calc_tag

    // Compare values up to 64 bits
    task automatic check_val(input string name, input logic [OUT_W-1:0] e,
        input logic [OUT_W-1:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : check_val

    // Compare single flags
    task automatic check_flag(input string name, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, e, g);
        end
    endtask : check_flag

    // Verdict and end of run
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // Downstream: random accepts, forced on a packet end so nothing is overwritten
    always @(negedge clk_i)
    begin
        acc = out_packet_end | (!stall && ($random(seed_a) % 4 != 0));
        tacc = out_packet_end | (!stall && ($random(seed_a) % 2 != 0));
        if (out_word_valid === 1'b1 && acc)
        begin
            exp_e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check_val("out_word", exp_e[OUT_W-1:0], out_word);
            check_flag("out_packet_end", exp_e[OUT_W], out_packet_end);
        end
        if (out_tag_valid === 1'b1 && tacc)
            check_val("out_session_tag",
                tag_q.size() > 0 ? 64'(tag_q.pop_front()) : 'x, 64'(out_session_tag));
        out_word_accept_i <= acc;
        out_tag_accept_i <= tacc;
    end

    // One packet; expected entries pair words low half first
    task automatic send_packet(input int rx, input int ls, input int n);
        logic [IN_W-1:0] w;
        logic [IN_W-1:0] lo;
        int i;
        lo = DUMMY_WORD;
        tag_q.push_back(calc_tag(rx, ls));
        for (i = 0; i < n; i++)
        begin
            w = $random(seed);
            RX.send_word(rx, 2'(ls), i == 0, i == n - 1, $random(seed) % 8 == 0, w);
            if (i % 2 == 0)
                lo = w;
            else
                exp_q.push_back({i == n - 1, w, lo});
            if (gaps && $random(seed) % 3 == 0)
            begin
                @(negedge clk_i);
                RX.idle();
            end
        end
        if (n % 2 == 1)
            exp_q.push_back({1'b1, DUMMY_WORD, lo});
    endtask : send_packet

    // Release the receivers and wait for every entry to come out
    task automatic drain(input string name);
        int k;
        @(negedge clk_i);
        RX.idle();
        for (k = 0; k < 3000 && (exp_q.size() + tag_q.size()) != 0; k++)
            @(negedge clk_i);
        check_val("pending", 64'(0), 64'(exp_q.size() + tag_q.size()));
        $display("test %s done, mismatches %0d", name, miscompares);
    endtask : drain

    // Main sequence
    initial
    begin
        int rx;
        int k;
        nrst_i = 1'b0;
        stall = 1'b0;
        gaps = 1'b0;
        repeat (16) @(negedge clk_i);
        check_flag("ready in reset", 1'b0, in_word_ready);
        check_flag("valid in reset", 1'b0, out_word_valid);
        nrst_i = 1'b1;
        // Every session once, lengths 1 to 4, back to back
        for (rx = 0; rx < 16; rx++)
            send_packet(rx / 4, rx % 4, 1 + rx % 4);
        drain("sessions");
        // Random packets with idle gaps between words
        gaps = 1'b1;
        for (k = 0; k < 60; k++)
            send_packet($unsigned($random(seed)) % 4, $unsigned($random(seed)) % 4,
                1 + $unsigned($random(seed)) % 9);
        drain("random");
        // Downstream stalls while a long packet fills the buffer
        stall = 1'b1;
        gaps = 1'b0;
        fork
            send_packet(2, 3, 40);
        join_none
        for (k = 0; k < 50 && out_word_valid !== 1'b1; k++)
            @(negedge clk_i);
        check_flag("first word unaccepted", 1'b1, out_word_valid);
        check_flag("tag with first word", 1'b1, out_tag_valid);
        check_val("tag value", 64'(calc_tag(2, 3)), 64'(out_session_tag));
        repeat (60) @(negedge clk_i);
        check_flag("ready while full", 1'b0, in_word_ready);
        stall = 1'b0;
        wait fork;
        drain("fill");
        finish_test();
    end
endmodule : srca_adapter_tb_top
`default_nettype wire
